/* logic/twu_pkg.sv */
// Purpose: shared constants and types for the two-wire unit
// Assumes: 8-bit register port, 200 MHz system clock
// Notes: status codes are valid with the prescaler bits masked
package twu_pkg;
    // register offsets on the plain port
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_DATA = 4'h2;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h4;
    localparam logic [3:0] OFS_IRQ_EN = 4'h5;
    localparam logic [3:0] OFS_MODE = 4'h6;

    // control register layout
    typedef struct packed {
        logic flag;
        logic ack_en;
        logic start;
        logic stop;
        logic wcol;
        logic en;
        logic [1:0] rsvd;
    } twu_ctrl_t;
    localparam twu_ctrl_t CTRL_RST = 8'h00;

    // status codes, prescaler bits zero
    localparam logic [7:0] MASK_CODE = 8'hF8;
    localparam logic [7:0] C_START = 8'h08;
    localparam logic [7:0] C_RSTART = 8'h10;
    localparam logic [7:0] C_ADDR_ACK = 8'h18;
    localparam logic [7:0] C_ADDR_NACK = 8'h20;
    localparam logic [7:0] C_BYTE_ACK = 8'h28;
    localparam logic [7:0] C_BYTE_NACK = 8'h30;
    localparam logic [7:0] C_ARB_LOST = 8'h38;
    localparam logic [7:0] C_RADDR_ACK = 8'h40;
    localparam logic [7:0] C_RADDR_NACK = 8'h48;
    localparam logic [7:0] C_RX_ACK = 8'h50;
    localparam logic [7:0] C_RX_NACK = 8'h58;
    localparam logic [7:0] C_IDLE = 8'hF8;

    // sticky event bits
    localparam int EV_BYTE = 0;
    localparam int EV_ARB = 1;
    localparam int EV_WCOL = 2;
    localparam int EV_STOP = 3;
    localparam int EV_W = 4;

    // bus timing: bit period, quarter count at prescaler 0, four times longer per step
    localparam int CLK_PERIOD_NS = 5;
    localparam int BIT_PERIOD_NS = 160;
    localparam int QTR_CYCLES = (BIT_PERIOD_NS / 4) / CLK_PERIOD_NS;
    localparam int DIV_W = 10;

    // operating modes
    typedef enum logic [4:0] {
        MODE_NONE = 5'b00001,
        MODE_MASTER_SEND = 5'b00010,
        MODE_MASTER_RECEIVE = 5'b00100,
        MODE_SLAVE_SEND = 5'b01000,
        MODE_SLAVE_RECEIVE = 5'b10000
    } twu_mode_t;

    // byte engine states
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_START = 6'b000010,
        ST_BIT = 6'b000100,
        ST_ACK = 6'b001000,
        ST_WAIT = 6'b010000,
        ST_STOP = 6'b100000
    } twu_state_t;
endpackage

/* logic/twu_ctrl.sv */
// Purpose: byte-level master engine of the two-wire unit
// Assumes: open-drain scl/sda, pins sampled by sys_clk_i
// Notes: slave modes are only named in the mode type, never entered here
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps

module twu_ctrl (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    // quarter length for a prescaler setting
    function automatic logic [twu_pkg::DIV_W-1:0] qlen(input logic [1:0] p);
        qlen = twu_pkg::DIV_W'(twu_pkg::QTR_CYCLES) << {p, 1'b0};
    endfunction

    twu_pkg::twu_ctrl_t ctrl_q;
    twu_pkg::twu_state_t st_q, st_d;
    twu_pkg::twu_mode_t mode_q, mode_d;
    logic [1:0] presc_q;
    logic [7:0] data_q, code_q, code_d, sh_q, sh_d, rd_q;
    logic [2:0] bit_q, bit_d;
    logic [1:0] qt_q, qt_d;
    logic [twu_pkg::DIV_W-1:0] div_q;
    logic scl_m, scl_s, sda_m, sda_s, sda_p, busy_q;
    logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic rx_q, rx_d, adr_q, adr_d, ack_q, ack_d, rst_q, rst_d;
    logic hw_flag, arb, stop_done, rx_we;
    logic [twu_pkg::EV_W-1:0] ev_q, ev_en_q, ev_set;

    // register decode
    wire wr_ctrl = reg_we_i && reg_addr_i == twu_pkg::OFS_CTRL;
    wire wr_stat = reg_we_i && reg_addr_i == twu_pkg::OFS_STATUS;
    wire wr_data = reg_we_i && reg_addr_i == twu_pkg::OFS_DATA;
    wire wr_clr = reg_we_i && reg_addr_i == twu_pkg::OFS_IRQ_CLR;
    wire wr_en = reg_we_i && reg_addr_i == twu_pkg::OFS_IRQ_EN;
    wire twu_pkg::twu_ctrl_t wctl = reg_wdata_i;
    wire wcol = wr_data && !ctrl_q.flag;
    wire tx = adr_q || !rx_q;
    wire tick = div_q == qlen(presc_q) - 1'b1;
    // quarter 2 waits for scl really high, so a slow peer can stretch
    wire adv = tick && !(qt_q == 2'h2 && !scl_s);

    // read mux, status shows code with prescaler in low bits
    wire [7:0] stat_rd = {code_q[7:3], 1'b0, presc_q};
    wire [7:0] rd_mux =
        reg_addr_i == twu_pkg::OFS_CTRL ? ctrl_q :
        reg_addr_i == twu_pkg::OFS_STATUS ? stat_rd :
        reg_addr_i == twu_pkg::OFS_DATA ? data_q :
        reg_addr_i == twu_pkg::OFS_IRQ_STAT ? 8'(ev_q) :
        reg_addr_i == twu_pkg::OFS_IRQ_EN ? 8'(ev_en_q) :
        reg_addr_i == twu_pkg::OFS_MODE ? 8'(mode_q) : 8'h00;

    // two-flop pin synchronisers, third flop for edge of sda
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {scl_m, scl_s, sda_m, sda_s, sda_p} <= 5'h1F;
        end else begin
            {scl_m, scl_s} <= {scl_i, scl_m};
            {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
        end
    end

    // bus busy between a start and a stop seen on the wires
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q <= 1'b0;
        end else if (scl_s && sda_p && !sda_s) begin
            busy_q <= 1'b1;
        end else if (scl_s && !sda_p && sda_s) begin
            busy_q <= 1'b0;
        end
    end

    // quarter-bit divider, restarts on every state change
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= '0;
        end else if (tick || st_d != st_q || st_q == twu_pkg::ST_WAIT) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // byte engine
    always_comb begin
        st_d = st_q;
        qt_d = adv ? qt_q + 1'b1 : qt_q;
        bit_d = bit_q;
        sh_d = sh_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        code_d = code_q;
        rx_d = rx_q;
        adr_d = adr_q;
        ack_d = ack_q;
        rst_d = rst_q;
        mode_d = mode_q;
        hw_flag = 1'b0;
        arb = 1'b0;
        stop_done = 1'b0;
        rx_we = 1'b0;
        case (st_q)
            twu_pkg::ST_IDLE: begin
                scl_oe_d = 1'b0;
                sda_oe_d = 1'b0;
                qt_d = 2'h0;
                if (ctrl_q.en && ctrl_q.start && !ctrl_q.flag && !busy_q) begin
                    st_d = twu_pkg::ST_START;
                end
            end
            twu_pkg::ST_START: begin
                if (adv) begin
                    case (qt_q)
                        2'h0: sda_oe_d = 1'b0;
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: sda_oe_d = 1'b1;
                        default: begin
                            scl_oe_d = 1'b1;
                            hw_flag = 1'b1;
                            code_d = rst_q ? twu_pkg::C_RSTART : twu_pkg::C_START;
                            rst_d = 1'b1;
                            adr_d = 1'b1;
                            st_d = twu_pkg::ST_WAIT;
                        end
                    endcase
                end
            end
            // held here with scl low until software clears the flag
            twu_pkg::ST_WAIT: begin
                qt_d = 2'h0;
                if (!ctrl_q.flag) begin
                    if (ctrl_q.stop) begin
                        st_d = twu_pkg::ST_STOP;
                    end else if (ctrl_q.start) begin
                        st_d = twu_pkg::ST_START;
                    end else begin
                        st_d = twu_pkg::ST_BIT;
                        bit_d = 3'h7;
                        sh_d = tx ? data_q : 8'h00;
                    end
                end
            end
            twu_pkg::ST_BIT: begin
                if (adv) begin
                    case (qt_q)
                        2'h0: sda_oe_d = tx && !sh_q[7];
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: begin
                            sh_d = {sh_q[6:0], sda_s};
                            if (adr_q && bit_q == 3'h0) begin
                                rx_d = sh_q[7];
                                mode_d = sh_q[7] ? twu_pkg::MODE_MASTER_RECEIVE
                                                 : twu_pkg::MODE_MASTER_SEND;
                            end
                            // released a one but wire is low: another master won
                            if (tx && sh_q[7] && !sda_s) begin
                                arb = 1'b1;
                                hw_flag = 1'b1;
                                code_d = twu_pkg::C_ARB_LOST;
                                sda_oe_d = 1'b0;
                                rst_d = 1'b0;
                                mode_d = twu_pkg::MODE_NONE;
                                st_d = twu_pkg::ST_IDLE;
                            end
                        end
                        default: begin
                            scl_oe_d = 1'b1;
                            bit_d = bit_q - 1'b1;
                            if (bit_q == 3'h0) begin
                                st_d = twu_pkg::ST_ACK;
                            end
                        end
                    endcase
                end
            end
            twu_pkg::ST_ACK: begin
                if (adv) begin
                    case (qt_q)
                        2'h0: sda_oe_d = !tx && ctrl_q.ack_en;
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: ack_d = !sda_s;
                        default: begin
                            scl_oe_d = 1'b1;
                            hw_flag = 1'b1;
                            rx_we = !tx;
                            adr_d = 1'b0;
                            st_d = twu_pkg::ST_WAIT;
                            if (adr_q && !rx_q) begin
                                code_d = ack_q ? twu_pkg::C_ADDR_ACK
                                               : twu_pkg::C_ADDR_NACK;
                            end else if (adr_q) begin
                                code_d = ack_q ? twu_pkg::C_RADDR_ACK : twu_pkg::C_RADDR_NACK;
                            end else if (!rx_q) begin
                                code_d = ack_q ? twu_pkg::C_BYTE_ACK
                                               : twu_pkg::C_BYTE_NACK;
                            end else begin
                                code_d = ack_q ? twu_pkg::C_RX_ACK : twu_pkg::C_RX_NACK;
                            end
                        end
                    endcase
                end
            end
            twu_pkg::ST_STOP: begin
                if (adv) begin
                    case (qt_q)
                        2'h0: sda_oe_d = 1'b1;
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: sda_oe_d = 1'b1;
                        default: begin
                            sda_oe_d = 1'b0;
                            stop_done = 1'b1;
                            code_d = twu_pkg::C_IDLE;
                            rst_d = 1'b0;
                            mode_d = twu_pkg::MODE_NONE;
                            st_d = ctrl_q.start ? twu_pkg::ST_START : twu_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            default: st_d = twu_pkg::ST_IDLE;
        endcase
        // disabling the unit drops the wires at once
        if (!ctrl_q.en) begin
            st_d = twu_pkg::ST_IDLE;
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
            rst_d = 1'b0;
            mode_d = twu_pkg::MODE_NONE;
        end
    end

    // engine registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= twu_pkg::ST_IDLE;
            mode_q <= twu_pkg::MODE_NONE;
            {qt_q, bit_q, sh_q} <= 13'h0000;
            {scl_oe_q, sda_oe_q, rx_q, adr_q, ack_q, rst_q} <= 6'h00;
            code_q <= twu_pkg::C_IDLE;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            {qt_q, bit_q, sh_q} <= {qt_d, bit_d, sh_d};
            {scl_oe_q, sda_oe_q} <= {scl_oe_d, sda_oe_d};
            {rx_q, adr_q, ack_q, rst_q} <= {rx_d, adr_d, ack_d, rst_d};
            code_q <= code_d;
        end
    end

    // control register: flag is write-one-to-clear, hardware set wins
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= twu_pkg::CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                {ctrl_q.ack_en, ctrl_q.start, ctrl_q.en} <= {wctl.ack_en, wctl.start, wctl.en};
            end
            ctrl_q.flag <= hw_flag || (ctrl_q.flag && !(wr_ctrl && wctl.flag));
            ctrl_q.wcol <= wcol || (ctrl_q.wcol && !(wr_ctrl && wctl.wcol));
            ctrl_q.stop <= (wr_ctrl && wctl.stop) || (ctrl_q.stop && !stop_done);
            ctrl_q.rsvd <= 2'h0;
        end
    end

    // data, prescaler; data writes only land while the flag is set
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_q <= 8'hFF;
            presc_q <= 2'h0;
        end else begin
            if (rx_we) begin
                data_q <= sh_q;
            end else if (wr_data && ctrl_q.flag) begin
                data_q <= reg_wdata_i;
            end
            if (wr_stat) begin
                presc_q <= reg_wdata_i[1:0];
            end
        end
    end

    // sticky events, set wins over clear
    assign ev_set = {stop_done, wcol, arb, hw_flag};
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ev_q <= '0;
            ev_en_q <= '0;
        end else begin
            ev_q <= ev_set | (ev_q & ~(wr_clr ? reg_wdata_i[twu_pkg::EV_W-1:0] : '0));
            if (wr_en) begin
                ev_en_q <= reg_wdata_i[twu_pkg::EV_W-1:0];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= reg_re_i ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_o = rd_q;
    assign irq_o = |(ev_q & ev_en_q);
    // open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;
endmodule

/* verif/twu_slave_model.sv */
// Purpose: slave receiver on the far side of the two-wire bus
// Assumes: open-drain wires with pull-ups, master makes the clock
// Notes: behavioural; acknowledges unless nack_i is high
`timescale 1ns/100ps
module twu_slave_model (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic nack_i,
    output logic sda_oe_o,
    output logic [7:0] byte_o
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    initial sda_oe_o = 1'b0;
    initial byte_o = 8'h00;
    // start or stop frames the count afresh
    always @(sda_i) begin
        if (scl_i === 1'b1) cnt = 0;
    end
    // msb first, eight bits then the ack slot
    always @(posedge scl_i) begin
        if (cnt < 8) sh = {sh[6:0], sda_i};
        cnt = cnt + 1;
    end
    // pull low through the ack slot, release straight after
    always @(negedge scl_i) begin
        if (cnt == 8) begin
            byte_o = sh;
            sda_oe_o = !nack_i;
        end else if (cnt == 9) begin
            sda_oe_o = 1'b0;
            cnt = 0;
        end
    end
endmodule

/* verif/twu_ctrl_chk.sv */
// Purpose: port-level checks of the two-wire unit
// Assumes: prescaler 0, so a quarter is at least 8 cycles
// Notes: counts scl releases since the last control write
`timescale 1ns/100ps
module twu_ctrl_chk (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic ctl_wr;
    logic [3:0] rel_q;
    logic [9:0] age_q;
    assign ctl_wr = reg_we_i && reg_addr_i == twu_pkg::OFS_CTRL;
    // age saturates so a long idle never wraps into a false short one
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rel_q <= 4'h0;
            age_q <= 10'h000;
        end else if (ctl_wr) begin
            rel_q <= 4'h0;
            age_q <= 10'h000;
        end else begin
            rel_q <= rel_q + {3'h0, $fell(scl_oe_o)};
            age_q <= (age_q == 10'h3FF) ? age_q : age_q + 10'h001;
        end
    end
    sequence s_stop_req;
        ctl_wr && reg_wdata_i[7] && reg_wdata_i[4] && reg_wdata_i[2] && !reg_wdata_i[5];
    endsequence
    sequence s_bus_free;
        !scl_oe_o && !sda_oe_o;
    endsequence
    chk_stop_frees_bus: assert property (s_stop_req |-> ##[1:300] s_bus_free)
        else $error("stop request left the bus held");
    chk_flag_holds_scl: assert property (irq_o && scl_oe_o && !reg_we_i |=> scl_oe_o)
        else $error("clock released while flag pending");
    chk_byte_nine: assert property ($rose(irq_o) && scl_oe_o |-> rel_q == 4'h0 || rel_q == 4'h9)
        else $error("flag raised after wrong number of clock pulses");
    chk_byte_time: assert property ($rose(irq_o) && rel_q == 4'h9 |-> age_q >= 10'h120)
        else $error("flag raised before byte and ack slot ended");
    chk_status_bit2: assert property (reg_re_i && reg_addr_i == twu_pkg::OFS_STATUS |=> !reg_rdata_o[2])
        else $error("status bit 2 not zero");
    chk_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
        else $error("read data present without a read");
    chk_unmapped_zero: assert property (reg_re_i && reg_addr_i > 4'h6 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_irq_masked: assert property (reg_we_i && reg_addr_i == twu_pkg::OFS_IRQ_EN && reg_wdata_i == 8'h00 |=> !irq_o)
        else $error("interrupt high with all enables off");
endmodule
bind twu_ctrl twu_ctrl_chk chk_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o));

/* verif/twu_ctrl_tb.sv */
// Purpose: self-checking bench of the master send flow
// Assumes: pull-ups on both wires, prescaler left at 0
// Notes: software side masks and checks the status code at each flag
`timescale 1ns/100ps
module twu_ctrl_tb;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic nack = 1'b0;
    logic [7:0] lfsr_q = 8'h59;
    logic [7:0] rdata, got, rx_byte;
    logic irq, scl_oe, sda_oe, p_oe, scl_w, sda_w;
    logic scl_od, sda_od;
    int miscompares = 0;
    int total_checks = 0;
    int hi;
    // open-drain wires: a driver shows its level only while enabled, pull-ups do the rest
    assign scl_w = scl_oe ? scl_od : 1'b1;
    assign sda_w = (sda_oe ? sda_od : 1'b1) && !p_oe;
    always #2.5 sys_clk_i = !sys_clk_i;
    twu_ctrl dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq), .scl_i(scl_w), .scl_o(scl_od),
        .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_od), .sda_oe_o(sda_oe));
    twu_slave_model peer_u (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .sda_oe_o(p_oe), .byte_o(rx_byte));
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [7:0] byte_code(input logic nk);
        return nk ? twu_pkg::C_BYTE_NACK : twu_pkg::C_BYTE_ACK;
    endfunction
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one idle cycle after each strobe keeps every driver to one change per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge sys_clk_i);
        we <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        addr <= a;
        re <= 1'b1;
        @(posedge sys_clk_i);
        re <= 1'b0;
        #1 got = rdata;
        @(posedge sys_clk_i);
    endtask
    // bounded wait for the flag, then the masked code
    task automatic wait_code(input logic [7:0] exp);
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge sys_clk_i);
            n++;
            if (n == 2000) begin
                miscompares++;
                report_and_stop();
            end
        end
        rd(twu_pkg::OFS_STATUS);
        check("status", got & twu_pkg::MASK_CODE, exp);
    endtask
    task automatic send(input logic [7:0] d, input logic [7:0] exp);
        wr(twu_pkg::OFS_DATA, d);
        wr(twu_pkg::OFS_CTRL, 8'h84);
        wait_code(exp);
        check("peer byte", rx_byte, d);
        wr(twu_pkg::OFS_IRQ_CLR, 8'hFF);
    endtask
    task automatic start_bus();
        wr(twu_pkg::OFS_CTRL, 8'hA4);
        wait_code(twu_pkg::C_START);
        wr(twu_pkg::OFS_IRQ_CLR, 8'hFF);
    endtask
    task automatic stop_bus();
        int n;
        wr(twu_pkg::OFS_CTRL, 8'h94);
        got = 8'h10;
        for (n = 0; n < 100 && got[4] !== 1'b0; n++) rd(twu_pkg::OFS_CTRL);
        check("stop bit", got & 8'h10, 8'h00);
        check("bus idle", {6'h00, scl_w, sda_w}, 8'h03);
        wr(twu_pkg::OFS_IRQ_CLR, 8'hFF);
    endtask
    // watchdog well beyond the fifteen byte transfers of the run
    initial begin
        #150000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(twu_pkg::OFS_STATUS);
        check("status reset", got, twu_pkg::C_IDLE);
        rd(twu_pkg::OFS_MODE);
        check("mode reset", got, 8'h01);
        rd(4'h7);
        check("unmapped", got, 8'h00);
        wr(twu_pkg::OFS_IRQ_EN, 8'h0F);
        wr(twu_pkg::OFS_CTRL, 8'hA4);
        wait_code(twu_pkg::C_START);
        // flag pending: clock must stay low for 100 cycles, then irq follows the mask and the clear
        hi = 0;
        repeat (100) begin
            @(posedge sys_clk_i);
            if (scl_w) hi++;
        end
        check("held clock", hi[7:0], 8'h00);
        wr(twu_pkg::OFS_IRQ_EN, 8'h00);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(twu_pkg::OFS_IRQ_EN, 8'h0F);
        check("irq unmasked", {7'h00, irq}, 8'h01);
        wr(twu_pkg::OFS_IRQ_CLR, 8'hFF);
        check("irq cleared", {7'h00, irq}, 8'h00);
        nack <= 1'b1;
        send(8'hA0, twu_pkg::C_ADDR_NACK);
        nack <= 1'b0;
        stop_bus();
        // read direction, refused: only the address phase of the receive mode is reached
        start_bus();
        nack <= 1'b1;
        send(8'hA1, twu_pkg::C_RADDR_NACK);
        rd(twu_pkg::OFS_MODE);
        check("mode receive", got, 8'(twu_pkg::MODE_MASTER_RECEIVE));
        nack <= 1'b0;
        stop_bus();
        start_bus();
        send(8'hA0, twu_pkg::C_ADDR_ACK);
        rd(twu_pkg::OFS_MODE);
        check("mode send", got, 8'(twu_pkg::MODE_MASTER_SEND));
        // corner bytes first, then random ones with random refusals
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            nack <= (i > 1) && lfsr_q[7];
            send((i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lfsr_q, byte_code((i > 1) && lfsr_q[7]));
            // a refused byte ends the frame, so the write restarts from the address
            if ((i > 1) && lfsr_q[7]) begin
                nack <= 1'b0;
                stop_bus();
                start_bus();
                send(8'hA0, twu_pkg::C_ADDR_ACK);
            end
        end
        nack <= 1'b0;
        send(8'h5A, twu_pkg::C_BYTE_ACK);
        stop_bus();
        // data write with the flag clear is dropped and reported as a collision
        wr(twu_pkg::OFS_DATA, 8'h33);
        rd(twu_pkg::OFS_IRQ_STAT);
        check("write collision", got, 8'(1 << twu_pkg::EV_WCOL));
        rd(twu_pkg::OFS_DATA);
        check("data kept", got, 8'h5A);
        report_and_stop();
    end
endmodule
